// ### logic/seq_clock_regs.svh
// Register map, reset values and timing counts of the sequencer clock block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef SEQ_CLOCK_REGS_SVH
`define SEQ_CLOCK_REGS_SVH

// Register byte offsets
`define SECONDS_COUNTER_OFS    12'h000
`define SCAN_COUNTER_OFS       12'h004
`define CURRENT_SCAN_TIME_OFS  12'h008
`define MINIMUM_SCAN_TIME_OFS  12'h00C
`define MAXIMUM_SCAN_TIME_OFS  12'h010
`define PROG_CLOCK_SETTING_OFS 12'h014
`define RELAY_STATUS_OFS       12'h018

// Reset and limit values
`define PROG_CLOCK_SETTING_RST 16'h001E
`define PROG_CLOCK_SETTING_MIN 16'h0001
`define PROG_CLOCK_SETTING_MAX 16'h7FFF
`define SCAN_TIME_SAT          16'hFFFF
`define MIN_SCAN_TIME_RST      16'hFFFF

// Half periods and the second length in ms, counted on the 1 ms timebase tick
`define TENTH_HALF_MS          16'd50
`define FIFTH_HALF_MS          16'd100
`define ONE_HALF_MS            16'd500
`define TWO_HALF_MS            16'd1000
`define MS_PER_SECOND          16'd1000

// Relay status register field positions
`define RS_CONST_TRUE_BIT      0
`define RS_CONST_FALSE_BIT     1
`define RS_FIRST_ON_BIT        2
`define RS_FIRST_OFF_BIT       3
`define RS_TENTH_BIT           4
`define RS_FIFTH_BIT           5
`define RS_ONE_BIT             6
`define RS_TWO_BIT             7
`define RS_PROG_BIT            8
`define RS_OVERHEAT_BIT        9
`define RS_RESTART_OK_BIT      10

`endif

// ### logic/seq_clock_pkg.sv
// Types shared by the sequencer clock block and its bench.
// Assumes the register header carries all numeric constants.
package seq_clock_pkg;

    typedef enum logic [1:0] {
        RUN_STOPPED = 2'b00,
        RUN_FIRST   = 2'b01,
        RUN_STEADY  = 2'b10
    } run_state_e;

    typedef enum logic [2:0] {
        STOP_NONE        = 3'b000,
        STOP_RESET       = 3'b001,
        STOP_PROGRAM_END = 3'b010,
        STOP_BLOCK_STOP  = 3'b011,
        STOP_FEED_HOLD   = 3'b100
    } stop_cause_e;

    typedef struct packed {
        logic overheat_warning_relay;
        logic programmable_clock_relay;
        logic two_second_clock_relay;
        logic one_second_clock_relay;
        logic fifth_second_clock_relay;
        logic tenth_second_clock_relay;
        logic first_scan_off_relay;
        logic first_scan_on_relay;
        logic constant_false_relay;
        logic constant_true_relay;
    } relays_s;

endpackage : seq_clock_pkg

// ### logic/seq_clock_counters.sv
// Special relays, square-wave clocks, counters and scan timing of a sequencer.
// Assumes synchronous inputs, a one-cycle end_of_scan strobe and a one-cycle
// ms_tick every millisecond from a free-running timebase.
//
// Contract
// [R01] Constant true and false relays, refreshed
// [R02] First-scan-on high for first scan only
// [R03] First-scan-off low for first scan only
// [R04] Fixed clocks halve at 50/100/500/1000 ms
// [R05] Clock relays keep toggling while stopped
// [R06] Clock relays start low after reset
// [R07] Programmable clock half period n seconds
// [R08] Setting defaults 30, limited 1..32767
// [R09] Seconds counter counts while running, wraps
// [R10] Scan counter counts scans, wraps signed
// [R11] Current scan time in ms, saturating
// [R12] Minimum scan time kept at each end
// [R13] Maximum scan time excludes first scan
// [R14] Overheat warning follows alarm
// [R15] Overheat blocks restart after reset/program end
// [R16] Scans from strobe, time from ms tick
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "seq_clock_regs.svh"

module seq_clock_counters (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       run,
    input  wire logic                       end_of_scan,
    input  wire logic                       ms_tick,
    input  wire logic                       overheat_alarm,
    input  wire logic                       auto_running,
    input  wire seq_clock_pkg::stop_cause_e stop_cause,
    output seq_clock_pkg::relays_s          relays,
    output logic                            restart_permit
);
    import seq_clock_pkg::*;

    run_state_e  run_state_reg;
    logic        run_prev_reg;
    logic [15:0] tenth_cnt_reg;
    logic [15:0] fifth_cnt_reg;
    logic [15:0] one_cnt_reg;
    logic [15:0] two_cnt_reg;
    logic [15:0] sec_ms_cnt_reg;
    logic [15:0] prog_sec_cnt_reg;
    logic [15:0] seconds_counter_reg;
    logic [15:0] scan_counter_reg;
    logic [15:0] scan_ms_reg;
    logic [15:0] current_scan_time_reg;
    logic [15:0] minimum_scan_time_reg;
    logic [15:0] maximum_scan_time_reg;
    logic [15:0] prog_clock_setting_reg;
    logic        min_valid_reg;
    logic        const_true_reg;
    logic        const_false_reg;
    logic        first_on_reg;
    logic        first_off_reg;
    logic        tenth_clk_reg;
    logic        fifth_clk_reg;
    logic        one_clk_reg;
    logic        two_clk_reg;
    logic        prog_clk_reg;
    logic        overheat_reg;
    stop_cause_e last_stop_reg;
    logic        second_tick;
    logic        run_rise;
    logic        bus_access;
    logic        wr_fire;
    logic [15:0] scan_time_next;
    logic [15:0] prog_setting_next;
    logic [31:0] rd_next;
    logic        rd_err_next;

    // Plain 16-bit step; wraps 7FFF to 8000 and FFFF to 0000 by nature
    function automatic logic [15:0] inc16(input logic [15:0] val);
        inc16 = val + 16'd1;
    endfunction : inc16

    // Half-period counter: true when the count has reached its last tick
    function automatic logic half_done(input logic [15:0] cnt, input logic [15:0] half);
        half_done = (cnt == half - 16'd1);
    endfunction : half_done

    function automatic logic [15:0] half_step(input logic [15:0] cnt, input logic [15:0] half);
        half_step = half_done(cnt, half) ? 16'd0 : inc16(cnt);
    endfunction : half_step

    // Only writable word
    function automatic logic setting_addr(input logic [11:0] addr);
        setting_addr = (addr == `PROG_CLOCK_SETTING_OFS);
    endfunction : setting_addr

    assign run_rise    = run && !run_prev_reg;
    assign second_tick = ms_tick && half_done(sec_ms_cnt_reg, `MS_PER_SECOND);
    assign bus_access  = psel && penable;
    assign wr_fire     = bus_access && pready && pwrite;

    // One flop per relay, with related relays sharing a process; the port is pure wiring
    assign relays = {
        overheat_reg,
        prog_clk_reg,
        two_clk_reg,
        one_clk_reg,
        fifth_clk_reg,
        tenth_clk_reg,
        first_off_reg,
        first_on_reg,
        const_false_reg,
        const_true_reg
    };

    // Run state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_prev_reg  <= 1'b0;
            run_state_reg <= RUN_STOPPED;
        end else begin
            run_prev_reg <= run;
            case (run_state_reg)
                RUN_STOPPED: begin
                    if (run_rise) begin
                        run_state_reg <= RUN_FIRST;
                    end
                end
                RUN_FIRST: begin
                    if (!run) begin
                        run_state_reg <= RUN_STOPPED;
                    // [R16] scan boundary strobe
                    end else if (end_of_scan) begin
                        run_state_reg <= RUN_STEADY;
                    end
                end
                RUN_STEADY: begin
                    if (!run) begin
                        run_state_reg <= RUN_STOPPED;
                    end
                end
                default: begin
                    run_state_reg <= RUN_STOPPED;
                end
            endcase
        end
    end

    // Constant and first-scan relays
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            const_true_reg  <= 1'b1;
            const_false_reg <= 1'b0;
            first_on_reg    <= 1'b0;
            first_off_reg   <= 1'b0;
        end else begin
            // [R01] refresh at end
            if (end_of_scan) begin
                const_true_reg  <= 1'b1;
                const_false_reg <= 1'b0;
            end
            // [R02] on for first scan
            // [R03] off for first scan
            if (run_rise) begin
                first_on_reg  <= 1'b1;
                first_off_reg <= 1'b0;
            end else if (end_of_scan && run_state_reg == RUN_FIRST) begin
                first_on_reg  <= 1'b0;
                first_off_reg <= 1'b1;
            end
        end
    end

    // Fixed square-wave clocks; run state is ignored on purpose
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tenth_cnt_reg <= 16'h0000;
            fifth_cnt_reg <= 16'h0000;
            one_cnt_reg   <= 16'h0000;
            two_cnt_reg   <= 16'h0000;
            // [R06] start from low
            tenth_clk_reg <= 1'b0;
            fifth_clk_reg <= 1'b0;
            one_clk_reg   <= 1'b0;
            two_clk_reg   <= 1'b0;
        // [R05] free-running, even stopped
        end else if (ms_tick) begin
            // [R04] fixed half periods
            tenth_cnt_reg <= half_step(tenth_cnt_reg, `TENTH_HALF_MS);
            fifth_cnt_reg <= half_step(fifth_cnt_reg, `FIFTH_HALF_MS);
            one_cnt_reg   <= half_step(one_cnt_reg, `ONE_HALF_MS);
            two_cnt_reg   <= half_step(two_cnt_reg, `TWO_HALF_MS);
            if (half_done(tenth_cnt_reg, `TENTH_HALF_MS)) begin
                tenth_clk_reg <= !tenth_clk_reg;
            end
            if (half_done(fifth_cnt_reg, `FIFTH_HALF_MS)) begin
                fifth_clk_reg <= !fifth_clk_reg;
            end
            if (half_done(one_cnt_reg, `ONE_HALF_MS)) begin
                one_clk_reg <= !one_clk_reg;
            end
            if (half_done(two_cnt_reg, `TWO_HALF_MS)) begin
                two_clk_reg <= !two_clk_reg;
            end
        end
    end

    // Programmable clock, stepped by the free-running second tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_ms_cnt_reg   <= 16'h0000;
            prog_sec_cnt_reg <= 16'h0000;
            prog_clk_reg     <= 1'b0;
        end else begin
            if (ms_tick) begin
                sec_ms_cnt_reg <= half_step(sec_ms_cnt_reg, `MS_PER_SECOND);
            end
            // [R07] half period n seconds
            if (second_tick) begin
                // Compare with >= so a smaller new setting takes effect at once
                if (inc16(prog_sec_cnt_reg) >= prog_clock_setting_reg) begin
                    prog_sec_cnt_reg <= 16'h0000;
                    prog_clk_reg     <= !prog_clk_reg;
                end else begin
                    prog_sec_cnt_reg <= inc16(prog_sec_cnt_reg);
                end
            end
        end
    end

    // Seconds and scan counters; 16-bit adds wrap 7FFF to 8000 by nature
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seconds_counter_reg <= 16'h0000;
            scan_counter_reg    <= 16'h0000;
        end else begin
            // [R09] count while running
            if (second_tick && run_state_reg != RUN_STOPPED) begin
                seconds_counter_reg <= inc16(seconds_counter_reg);
            end
            // [R10] count each scan
            if (end_of_scan && run_state_reg != RUN_STOPPED) begin
                scan_counter_reg <= inc16(scan_counter_reg);
            end
        end
    end

    // Elapsed time of the scan in progress, saturating
    always_comb begin
        scan_time_next = scan_ms_reg;
        if (ms_tick && scan_ms_reg != `SCAN_TIME_SAT) begin
            scan_time_next = inc16(scan_ms_reg);
        end
    end

    // Scan timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_ms_reg           <= 16'h0000;
            current_scan_time_reg <= 16'h0000;
            minimum_scan_time_reg <= `MIN_SCAN_TIME_RST;
            maximum_scan_time_reg <= 16'h0000;
            min_valid_reg         <= 1'b0;
        end else begin
            // [R16] ms timebase measures scan
            if (run_rise || end_of_scan) begin
                scan_ms_reg <= 16'h0000;
            end else begin
                scan_ms_reg <= scan_time_next;
            end
            if (end_of_scan && run_state_reg != RUN_STOPPED) begin
                // [R11] store last scan time
                current_scan_time_reg <= scan_time_next;
                // [R12] track smallest scan
                if (!min_valid_reg || scan_time_next < minimum_scan_time_reg) begin
                    minimum_scan_time_reg <= scan_time_next;
                end
                min_valid_reg <= 1'b1;
                // [R13] first scan excluded
                if (run_state_reg == RUN_STEADY && scan_time_next > maximum_scan_time_reg) begin
                    maximum_scan_time_reg <= scan_time_next;
                end
            end
        end
    end

    // Overheat and restart gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overheat_reg   <= 1'b0;
            last_stop_reg  <= STOP_NONE;
            restart_permit <= 1'b1;
        end else begin
            // [R14] follow alarm
            overheat_reg <= overheat_alarm;
            if (stop_cause != STOP_NONE) begin
                last_stop_reg <= stop_cause;
            end
            // [R15] block reset/end restart
            // A running cycle is never cut; only a fresh start is gated
            restart_permit <= auto_running || !overheat_alarm
                              || (last_stop_reg != STOP_RESET && last_stop_reg != STOP_PROGRAM_END);
        end
    end

    // Setting write with clamp into the legal range
    always_comb begin
        prog_setting_next = pwdata[15:0];
        if (pwdata[15:0] < `PROG_CLOCK_SETTING_MIN) begin
            prog_setting_next = `PROG_CLOCK_SETTING_MIN;
        end else if (pwdata[15:0] > `PROG_CLOCK_SETTING_MAX) begin
            prog_setting_next = `PROG_CLOCK_SETTING_MAX;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // [R08] default 30
            prog_clock_setting_reg <= `PROG_CLOCK_SETTING_RST;
        end else if (wr_fire && setting_addr(paddr)) begin
            // [R08] clamp 1..32767
            prog_clock_setting_reg <= prog_setting_next;
        end
    end

    // Read decode
    always_comb begin
        rd_next     = 32'h0000_0000;
        rd_err_next = 1'b0;
        if (paddr == `SECONDS_COUNTER_OFS) begin
            rd_next[15:0] = seconds_counter_reg;
        end else if (paddr == `SCAN_COUNTER_OFS) begin
            rd_next[15:0] = scan_counter_reg;
        end else if (paddr == `CURRENT_SCAN_TIME_OFS) begin
            rd_next[15:0] = current_scan_time_reg;
        end else if (paddr == `MINIMUM_SCAN_TIME_OFS) begin
            rd_next[15:0] = min_valid_reg ? minimum_scan_time_reg : 16'h0000;
        end else if (paddr == `MAXIMUM_SCAN_TIME_OFS) begin
            rd_next[15:0] = maximum_scan_time_reg;
        end else if (setting_addr(paddr)) begin
            rd_next[15:0] = prog_clock_setting_reg;
        end else if (paddr == `RELAY_STATUS_OFS) begin
            rd_next[`RS_OVERHEAT_BIT:`RS_CONST_TRUE_BIT] = relays;
            rd_next[`RS_RESTART_OK_BIT]                  = restart_permit;
        end else begin
            rd_err_next = 1'b1;
        end
        // Read-only registers refuse writes
        if (pwrite && !setting_addr(paddr)) begin
            rd_err_next = 1'b1;
        end
    end

    // APB answer: one wait state so every output comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= bus_access && !pready;
            pslverr <= bus_access && !pready && rd_err_next;
            if (bus_access && !pready && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

endmodule : seq_clock_counters

// ### test/seq_clock_chk.sv
// Port-level assertions for the sequencer clock block.
// Assumes a bind onto seq_clock_counters; single pclk domain.
`timescale 1ns/1ps

module seq_clock_chk (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    run,
    input wire logic                    end_of_scan,
    input wire logic                    ms_tick,
    input wire logic                    overheat_alarm,
    input wire seq_clock_pkg::relays_s  relays
);
    import seq_clock_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    sequence done_s;
        psel && penable && pready;
    endsequence

    const_relays_a: assert property (relays.constant_true_relay && !relays.constant_false_relay)
        else $error("constant relays wrong");
    first_scan_start_a: assert property ($rose(run) |-> ##[1:2]
        (relays.first_scan_on_relay && !relays.first_scan_off_relay)) else $error("first scan not flagged");
    first_scan_end_a: assert property (relays.first_scan_on_relay && run && end_of_scan
        |=> !relays.first_scan_on_relay && relays.first_scan_off_relay) else $error("first scan flag stuck");
    clock_tick_a: assert property ($changed({relays.tenth_second_clock_relay, relays.fifth_second_clock_relay,
        relays.one_second_clock_relay, relays.two_second_clock_relay, relays.programmable_clock_relay})
        |-> $past(ms_tick)) else $error("clock relay moved without tick");
    overheat_follow_a: assert property ($changed(overheat_alarm)
        |=> relays.overheat_warning_relay == $past(overheat_alarm)) else $error("overheat relay late");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    apb_wait_a: assert property (setup_s ##1 access_s |=> pready)
        else $error("apb answer not after one wait");
    unmapped_err_a: assert property (done_s ##0 (paddr > 12'h018) |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    ro_write_a: assert property (done_s ##0 (pwrite && paddr != 12'h014) |-> pslverr)
        else $error("read-only write not refused");
endmodule : seq_clock_chk

bind seq_clock_counters seq_clock_chk u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .run(run),
    .end_of_scan(end_of_scan),
    .ms_tick(ms_tick),
    .overheat_alarm(overheat_alarm),
    .relays(relays)
);

// ### test/tb.sv
// Self-checking bench for the sequencer clock block, with a cycle model.
// Assumes ms_tick may pulse fast; times are counted in ticks.
`timescale 1ns/1ps
`include "seq_clock_regs.svh"

module tb;
    import seq_clock_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, restart_permit, er;
    logic        run = 0, end_of_scan = 0, ms_tick = 0, overheat_alarm = 0, auto_running = 0;
    logic        tick_en = 0, running = 0, first = 0, run_q = 0, ov_q = 0;
    stop_cause_e stop_cause = STOP_NONE;
    relays_s     relays;
    int          err_total = 0, checked = 0;
    int          tk = 0, secs = 0, scans = 0, scnt = 0, cur = 0, mn = 65535, mx = 0;
    int          exp_q[5];
    logic [31:0] wv[4] = '{32'h0, 32'h8000, 32'h7FFF, 32'h1};
    logic [31:0] ev[4] = '{32'h1, 32'h7FFF, 32'h7FFF, 32'h1};

    seq_clock_counters u_seq_clock_counters (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run(run), .end_of_scan(end_of_scan),
        .ms_tick(ms_tick), .overheat_alarm(overheat_alarm), .auto_running(auto_running),
        .stop_cause(stop_cause), .relays(relays), .restart_permit(restart_permit)
    );

    always #2 pclk = ~pclk;

    // Never two ticks back to back, like a real timebase
    always @(posedge pclk) begin
        ms_tick <= tick_en && !ms_tick && ($urandom % 2 == 1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Reference model, fed by the same sampled inputs as the design
    always @(posedge pclk) begin
        if (presetn) begin
            ov_q = overheat_alarm;
            if (ms_tick) begin
                tk++;
                if (tk % 1000 == 0 && running) secs++;
                if (running) scnt++;
            end
            // scan times, first scan kept out of max
            if (running && end_of_scan) begin
                cur = scnt > 65535 ? 65535 : scnt;
                mn = cur < mn ? cur : mn;
                if (!first) mx = cur > mx ? cur : mx;
                first = 0;
                scans++;
                scnt = 0;
            end
            if (run && !run_q) begin
                running = 1;
                first = 1;
                scnt = 0;
            end
            if (!run) running = 0;
            run_q = run;
        end
    end

    always @(negedge pclk) begin
        if (presetn) begin
            check(relays.constant_true_relay, 1'b1);
            check(relays.constant_false_relay, 1'b0);
            check(relays.tenth_second_clock_relay, (tk / 50) % 2);
            check(relays.fifth_second_clock_relay, (tk / 100) % 2);
            check(relays.one_second_clock_relay, (tk / 500) % 2);
            check(relays.two_second_clock_relay, (tk / 1000) % 2);
            check(relays.programmable_clock_relay, (tk / 1000) % 2);
            check(relays.overheat_warning_relay, ov_q);
            if (running) begin
                check(relays.first_scan_on_relay, first);
                check(relays.first_scan_off_relay, !first);
            end
        end
    end

    initial begin
        #(50000 * 4);
        err_total++;
        print_verdict();
    end

    initial begin
        void'($urandom(44));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(restart_permit, 1'b1);
        apb(1'b0, `PROG_CLOCK_SETTING_OFS, 32'h0);
        check(rd, 32'h1E);
        // Setting ends at 1 before the first second, so model uses n = 1
        foreach (wv[i]) begin
            apb(1'b1, `PROG_CLOCK_SETTING_OFS, wv[i]);
            check(er, 1'b0);
            apb(1'b0, `PROG_CLOCK_SETTING_OFS, 32'h0);
            check(rd, ev[i]);
        end
        for (int a = 0; a < 8; a++) begin
            // Setting word gets 1 so the model's n = 1 still holds
            apb(1'b1, 12'(a * 4), (a == 5) ? 32'h1 : 32'hFFFF);
            check(er, a != 5);
        end
        apb(1'b0, 12'h01C, 32'h0);
        check({rd[30:0], er}, 32'h1);
        $display("Test registers done");
        tick_en <= 1'b1;
        repeat (1500) @(posedge pclk);
        $display("Test stopped clocks done");
        // Ticks held off across the run edge, where counting is undefined
        tick_en <= 1'b0;
        repeat (3) @(posedge pclk);
        run <= 1'b1;
        repeat (2) @(posedge pclk);
        tick_en <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            repeat (100 + $urandom % 800) @(posedge pclk);
            end_of_scan <= 1'b1;
            @(posedge pclk);
            end_of_scan <= 1'b0;
        end
        tick_en <= 1'b0;
        repeat (3) @(posedge pclk);
        exp_q = '{secs, scans, cur, mn, mx};
        foreach (exp_q[i]) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            check(rd, exp_q[i] & 32'hFFFF);
        end
        $display("Test run and scans done");
        for (int c = 1; c < 5; c++) begin
            overheat_alarm <= 1'b1;
            auto_running <= 1'b0;
            stop_cause <= stop_cause_e'(c);
            @(posedge pclk);
            stop_cause <= STOP_NONE;
            repeat (3) @(posedge pclk);
            check(restart_permit, c > 2);
            auto_running <= 1'b1;
            overheat_alarm <= (c % 2 == 1);
            repeat (3) @(posedge pclk);
            check(restart_permit, 1'b1);
        end
        overheat_alarm <= 1'b0;
        $display("Test overheat done");
        run <= 1'b0;
        tick_en <= 1'b1;
        repeat (1200) @(posedge pclk);
        end_of_scan <= 1'b1;
        @(posedge pclk);
        end_of_scan <= 1'b0;
        tick_en <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, `SCAN_COUNTER_OFS, 32'h0);
        check(rd, scans);
        $display("Test stop done");
        print_verdict();
    end
endmodule : tb
